// ---- hdl/sfpc_pkg.sv ----
/*
  Shared constants and carriers for the serial flash erase, suspend and power control block.
  Assumes a single 250 MHz core clock that samples the host serial pins.
*/
//
// Contract
// - Opcodes C7h and 60h without address start a whole-array erase to all ones.
// - Whole-array erase is accepted only while the write latch flag is set.
// - Erase executes only if select rises right after the eighth opcode bit.
// - After select rises busy stays high for the self-timed erase, status still readable.
// - Finishing the whole-array erase clears the write latch flag.
// - Any protected page blocks the whole-array erase from starting.
// - Opcode 75h pauses an ongoing sector or block erase or page program.
// - During erase suspend, status write and all erase opcodes are refused.
// - During program suspend, status write and program opcodes are refused.
// - Suspend during a whole-array erase is ignored.
// - Suspend acts only with suspend flag clear and busy set.
// - Accepted suspend sets suspend flag at once, drops busy within suspend latency.
// - After power loss the suspend state is released and a stale resume ignored.
// - Resume needs suspend flag set and busy clear; clears flag, busy within 200ns.
// - Power-down opcode B9h needs select high after bit eight, enters after entry time.
// - While powered down only the release opcode is recognised.
// - The device always starts in normal mode after power-up.
// - Release opcode alone wakes the device after the wake time.
// - Release followed by three dummy bytes shifts the ID out MSB first, repeating.
// - Release or ID opcode while busy is ignored and leaves the cycle intact.
package sfpc_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_ERASE_ALL_A = 8'hC7;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_SECURITY_ERASE = 8'h44;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECURITY_PROGRAM = 8'h42;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESUME_BUSY_NS = 200;
  localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS * 1000) / CLK_PERIOD_PS;
  localparam int DUMMY_BYTES = 3;
  localparam int ID_START_BIT = 8 * (1 + DUMMY_BYTES);

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_WRITE_LATCH = 1'b0;
  localparam logic RST_SUSPEND = 1'b0;
  localparam logic RST_POWERED_DOWN = 1'b0;

  typedef enum {
    SFPC_IDLE,
    SFPC_ERASE_ALL,
    SFPC_OTHER_BUSY,
    SFPC_SUSPENDING,
    SFPC_SUSPENDED,
    SFPC_RESUMING,
    SFPC_PD_ENTER,
    SFPC_PD,
    SFPC_WAKE
  } sfpc_mode_e;

  // A four-state base lets this type travel on a wire port.
  typedef enum logic [1:0] {
    SFPC_OP_NONE,
    SFPC_OP_ERASE,
    SFPC_OP_PROGRAM
  } sfpc_kind_e;

  typedef struct packed {
    logic [5:0] protect_level;
    logic protect_top_bottom;
    logic protect_sector_granule;
    logic protect_complement;
  } sfpc_protect_s;

  typedef struct packed {
    logic busy;
    logic write_latch_flag;
    logic suspend_flag;
    logic powered_down;
  } sfpc_status_s;

  // A frame is one select-low period: its opcode and how many bits it carried.
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] bit_count;
  } sfpc_frame_s;

  // Any set protect-level bit, or the complement bit, guards at least one page.
  function automatic logic sfpc_any_protected(input sfpc_protect_s p);
    return p.protect_complement ? 1'b1 : (p.protect_level != '0);
  endfunction

  function automatic logic sfpc_is_erase_op(input logic [7:0] op);
    return (op == OP_SECTOR_ERASE) || (op == OP_BLOCK32_ERASE) || (op == OP_BLOCK64_ERASE)
      || (op == OP_ERASE_ALL_A) || (op == OP_ERASE_ALL_B) || (op == OP_SECURITY_ERASE);
  endfunction

  function automatic logic sfpc_is_program_op(input logic [7:0] op);
    return (op == OP_PAGE_PROGRAM) || (op == OP_QUAD_PROGRAM) || (op == OP_SECURITY_PROGRAM);
  endfunction

endpackage

// ---- hdl/sfpc_sync.sv ----
/*
  Two-flop synchroniser for the host pins.
  Assumes inputs are asynchronous to clk; only the second stage is read outside.
*/
`timescale 1ns/10ps
`default_nettype none
module sfpc_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sfpc_sync_s;

  sfpc_sync_s st_r;
  sfpc_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= {INIT, INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;
endmodule // sfpc_sync
`default_nettype wire

// ---- hdl/sfpc_frame.sv ----
/*
  Serial front end: finds clock edges and select edges, shifts opcode bits,
  and shifts the device ID out on falling edges after the dummy bytes.
  Assumes synchronised pin levels from sfpc_sync.
*/
`timescale 1ns/10ps
`default_nettype none
module sfpc_frame
  import sfpc_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5A  // Arbitrary neutral value.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic id_enable,
  output sfpc_frame_s frame,
  output logic frame_start,
  output logic frame_end,
  output logic status_bit_edge,
  output logic sdo,
  output logic sdo_oe
);
  typedef struct packed {
    logic sel_n_d;
    logic sck_d;
    logic [7:0] opcode;
    logic [15:0] bit_count;
    logic [2:0] id_bit;
    logic sdo;
    logic sdo_oe;
  } sfpc_frame_state_s;

  sfpc_frame_state_s st_r;
  sfpc_frame_state_s st_nxt;
  logic rise;
  logic fall;

  always_comb begin
    st_nxt = st_r;
    rise = sck & ~st_r.sck_d;
    fall = ~sck & st_r.sck_d;
    st_nxt.sel_n_d = sel_n;
    st_nxt.sck_d = sck;
    if (st_r.sel_n_d & ~sel_n) begin
      st_nxt.opcode = '0;
      st_nxt.bit_count = '0;
      st_nxt.id_bit = 3'h7;
    end else if (!sel_n && rise) begin
      if (st_r.bit_count < 16'h0008) begin
        st_nxt.opcode = {st_r.opcode[6:0], sdi};
      end
      if (st_r.bit_count != 16'hFFFF) begin
        st_nxt.bit_count = st_r.bit_count + 16'h0001;
      end
    end
    if (!sel_n && fall && id_enable && (st_r.opcode == OP_RELEASE)
        && (st_r.bit_count >= 16'(ID_START_BIT))) begin
      st_nxt.sdo = DEVICE_ID[st_r.id_bit];
      st_nxt.sdo_oe = 1'b1;
      st_nxt.id_bit = st_r.id_bit - 3'h1;
    end
    if (sel_n) begin
      st_nxt.sdo_oe = 1'b0;
      st_nxt.sdo = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{sel_n_d: 1'b1, sck_d: 1'b0, opcode: 8'h00, bit_count: 16'h0000,
                id_bit: 3'h7, sdo: 1'b0, sdo_oe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign frame.opcode = st_r.opcode;
  assign frame.bit_count = st_r.bit_count;
  assign frame_start = st_r.sel_n_d & ~sel_n;
  assign frame_end = ~st_r.sel_n_d & sel_n;
  assign status_bit_edge = fall;
  assign sdo = st_r.sdo;
  assign sdo_oe = st_r.sdo_oe;
endmodule // sfpc_frame
`default_nettype wire

// ---- hdl/sfpc_top.sv ----
/*
  Command control for whole-array erase, suspend and resume, power-down and
  release with device ID readout, inside a serial flash.
  Assumes a host SPI controller on select, clock and data; other operations
  (sector erase, program, status write) run elsewhere and report through
  other_busy_start and other_done, and other_kind tells erase from program.
*/
`timescale 1ns/10ps
`default_nettype none
module sfpc_top
  import sfpc_pkg::*;
#(
  parameter int ERASE_ALL_CYC = 8192,
  parameter int SUSPEND_LATENCY_CYC = 5000,
  parameter int POWER_DOWN_ENTRY_CYC = 750,
  parameter int WAKE_CYC = 750,
  parameter int WAKE_WITH_ID_TIME_CYC = 450,
  parameter logic [7:0] DEVICE_ID = 8'h5A  // Arbitrary neutral value.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdi,
  input wire sfpc_pkg::sfpc_protect_s protect,
  input wire logic write_enable_set,
  input wire logic other_busy_start,
  input wire sfpc_pkg::sfpc_kind_e other_kind,
  input wire logic other_done,
  output logic sdo,
  output logic sdo_oe,
  output sfpc_pkg::sfpc_status_s status,
  output logic erase_all_fill,
  output logic [7:0] erase_all_value,
  output logic op_pause,
  output sfpc_pkg::sfpc_kind_e suspended_kind,
  output logic cmd_refused,
  output logic [7:0] accepted_opcode,
  output logic accepted_strobe
);
  import sfpc_pkg::*;

  if (ERASE_ALL_CYC < 1 || SUSPEND_LATENCY_CYC < 1 || POWER_DOWN_ENTRY_CYC < 1
      || WAKE_CYC < 1 || WAKE_WITH_ID_TIME_CYC < 1) begin : g_bad_counts
    $error("sfpc_top: every cycle count must be at least one");
  end

  // ****************************************
  // Pin synchronisation and framing
  // ****************************************
  logic [2:0] pins_s;
  sfpc_frame_s frame;
  logic frame_end;
  logic fr_sdo;
  logic fr_sdo_oe;
  logic id_enable;

  sfpc_sync #(.WIDTH(3), .INIT(3'b100)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({sel_n, sck, sdi}),
    .q(pins_s)
  );

  sfpc_frame #(.DEVICE_ID(DEVICE_ID)) u_frame (
    .clk(clk),
    .rst(rst),
    .sel_n(pins_s[2]),
    .sck(pins_s[1]),
    .sdi(pins_s[0]),
    .id_enable(id_enable),
    .frame(frame),
    .frame_start(),
    .frame_end(frame_end),
    .status_bit_edge(),
    .sdo(fr_sdo),
    .sdo_oe(fr_sdo_oe)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sfpc_mode_e mode;
    sfpc_kind_e kind;
    logic write_latch_flag;
    logic suspend_flag;
    logic [31:0] count;
    logic id_wake;
    logic sdo;
    logic sdo_oe;
    logic fill;
    logic refused;
    logic [7:0] acc_op;
    logic acc_strobe;
  } sfpc_state_s;

  sfpc_state_s st_r;
  sfpc_state_s st_nxt;
  logic busy_now;
  logic exact_eight;
  logic [7:0] op;

  // Status reads are not decoded here; the frame's readout is only the ID.
  // The ID stays off while busy or while entering or leaving power-down; in power-down
  // it is served, since the same frame that reads it also wakes the device.
  assign id_enable = (st_r.mode == SFPC_IDLE) || (st_r.mode == SFPC_SUSPENDED)
    || (st_r.mode == SFPC_PD);

  always_comb begin
    st_nxt = st_r;
    op = frame.opcode;
    exact_eight = (frame.bit_count == 16'h0008);
    busy_now = (st_r.mode == SFPC_ERASE_ALL) || (st_r.mode == SFPC_OTHER_BUSY)
      || (st_r.mode == SFPC_SUSPENDING) || (st_r.mode == SFPC_RESUMING);
    st_nxt.refused = 1'b0;
    st_nxt.acc_strobe = 1'b0;
    st_nxt.fill = 1'b0;
    st_nxt.sdo = fr_sdo;
    st_nxt.sdo_oe = fr_sdo_oe;
    if (st_r.count != '0) begin
      st_nxt.count = st_r.count - 32'd1;
    end

    if (write_enable_set && !busy_now && (st_r.mode != SFPC_PD)
        && (st_r.mode != SFPC_PD_ENTER) && (st_r.mode != SFPC_WAKE)) begin
      st_nxt.write_latch_flag = 1'b1;
    end

    case (st_r.mode)
      SFPC_IDLE, SFPC_SUSPENDED: begin
        if (other_busy_start && st_r.mode == SFPC_IDLE) begin
          st_nxt.mode = SFPC_OTHER_BUSY;
          st_nxt.kind = other_kind;
        end else if (frame_end && exact_eight) begin
          if ((op == OP_ERASE_ALL_A) || (op == OP_ERASE_ALL_B)) begin
            if (st_r.mode == SFPC_SUSPENDED) begin
              st_nxt.refused = 1'b1;
            end else if (!st_r.write_latch_flag) begin
              st_nxt.refused = 1'b1;
            end else if (sfpc_any_protected(protect)) begin
              st_nxt.refused = 1'b1;
            end else begin
              st_nxt.mode = SFPC_ERASE_ALL;
              st_nxt.count = 32'(ERASE_ALL_CYC);
              st_nxt.fill = 1'b1;
            end
          end else if ((op == OP_RESUME) && (st_r.mode == SFPC_SUSPENDED)
                       && st_r.suspend_flag) begin
            st_nxt.suspend_flag = 1'b0;
            st_nxt.mode = SFPC_RESUMING;
            st_nxt.count = 32'(RESUME_BUSY_CYC);
          end else if (op == OP_POWER_DOWN) begin
            st_nxt.mode = SFPC_PD_ENTER;
            st_nxt.count = 32'(POWER_DOWN_ENTRY_CYC);
          end else if (op == OP_RELEASE) begin
            st_nxt.acc_strobe = 1'b1;
          end
        end else if (frame_end && exact_eight && st_r.mode == SFPC_SUSPENDED) begin
          st_nxt.refused = 1'b1;
        end
        // Forwarded opcodes other blocks act on: status write always, erase or program by the suspend kind.
        if (frame_end && (frame.bit_count >= 16'h0008) && st_r.mode == SFPC_SUSPENDED) begin
          if ((op == OP_WRITE_STATUS)
              || ((st_r.kind == SFPC_OP_ERASE) && sfpc_is_erase_op(op))
              || ((st_r.kind == SFPC_OP_PROGRAM) && sfpc_is_program_op(op))) begin
            st_nxt.refused = 1'b1;
          end
        end
      end
      SFPC_ERASE_ALL: begin
        // Suspend arriving here is simply not decoded.
        if (st_r.count == 32'd1) begin
          st_nxt.mode = SFPC_IDLE;
          st_nxt.write_latch_flag = 1'b0;
        end
      end
      SFPC_OTHER_BUSY: begin
        if (other_done) begin
          st_nxt.mode = SFPC_IDLE;
          st_nxt.kind = SFPC_OP_NONE;
          st_nxt.write_latch_flag = 1'b0;
        end else if (frame_end && exact_eight && (op == OP_SUSPEND)
                     && !st_r.suspend_flag && (st_r.kind != SFPC_OP_NONE)) begin
          st_nxt.suspend_flag = 1'b1;
          st_nxt.mode = SFPC_SUSPENDING;
          st_nxt.count = 32'(SUSPEND_LATENCY_CYC);
        end
      end
      SFPC_SUSPENDING: begin
        if (st_r.count == 32'd1) begin
          st_nxt.mode = SFPC_SUSPENDED;
        end
      end
      SFPC_RESUMING: begin
        if (st_r.count <= 32'd1) begin
          st_nxt.mode = SFPC_OTHER_BUSY;
        end
      end
      SFPC_PD_ENTER: begin
        if (st_r.count == 32'd1) begin
          st_nxt.mode = SFPC_PD;
        end
      end
      SFPC_PD: begin
        // Only the release opcode is decoded here.
        if (frame_end && (op == OP_RELEASE) && (frame.bit_count >= 16'h0008)) begin
          st_nxt.mode = SFPC_WAKE;
          st_nxt.id_wake = (frame.bit_count >= 16'(ID_START_BIT));
          st_nxt.count = (frame.bit_count >= 16'(ID_START_BIT))
            ? 32'(WAKE_WITH_ID_TIME_CYC) : 32'(WAKE_CYC);
        end
      end
      SFPC_WAKE: begin
        if (st_r.count == 32'd1) begin
          st_nxt.mode = SFPC_IDLE;
          st_nxt.id_wake = 1'b0;
        end
      end
      default: begin
        st_nxt.mode = SFPC_IDLE;
      end
    endcase

    if (frame_end && (frame.bit_count >= 16'h0008)
        && (st_r.mode != SFPC_PD) && (st_r.mode != SFPC_WAKE)) begin
      st_nxt.acc_op = op;
    end
  end

  // Reset stands for power-up, so the suspend state and power-down always clear here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{mode: SFPC_IDLE, kind: SFPC_OP_NONE,
                write_latch_flag: RST_WRITE_LATCH,
                suspend_flag: RST_SUSPEND,
                count: 32'd0, id_wake: 1'b0, sdo: 1'b0, sdo_oe: 1'b0, fill: 1'b0,
                refused: 1'b0, acc_op: 8'h00, acc_strobe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic busy_r;
  logic pd_r;
  logic pause_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      pd_r <= RST_POWERED_DOWN;
      pause_r <= RST_SUSPEND;
    end else begin
      pause_r <= (st_nxt.mode == SFPC_SUSPENDED);
      busy_r <= (st_nxt.mode == SFPC_ERASE_ALL) || (st_nxt.mode == SFPC_OTHER_BUSY)
        || (st_nxt.mode == SFPC_SUSPENDING);
      pd_r <= (st_nxt.mode == SFPC_PD) || (st_nxt.mode == SFPC_WAKE);
    end
  end

  assign status.busy = busy_r;
  assign status.write_latch_flag = st_r.write_latch_flag;
  assign status.suspend_flag = st_r.suspend_flag;
  assign status.powered_down = pd_r;
  assign sdo = st_r.sdo;
  assign sdo_oe = st_r.sdo_oe;
  assign erase_all_fill = st_r.fill;
  assign erase_all_value = ERASED_BYTE;
  assign op_pause = pause_r;
  assign suspended_kind = st_r.kind;
  assign cmd_refused = st_r.refused;
  assign accepted_opcode = st_r.acc_op;
  assign accepted_strobe = st_r.acc_strobe;
endmodule // sfpc_top
`default_nettype wire

// ---- dv/sfpc_props.sv ----
/*
  Concurrent checks on the erase, suspend and power control top ports.
  Assumes one clock domain and the bind below to every sfpc_top instance.
*/
`timescale 1ns/10ps
`default_nettype none
module sfpc_props
  import sfpc_pkg::*;
#(
  parameter int SUSPEND_LATENCY_CYC = 5000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire sfpc_pkg::sfpc_protect_s protect,
  input wire sfpc_pkg::sfpc_status_s status,
  input wire logic erase_all_fill,
  input wire logic [7:0] erase_all_value,
  input wire logic cmd_refused,
  input wire logic sdo_oe
);
  import sfpc_pkg::*;
  // ****************************************
  // Sequences and properties
  // ****************************************
  localparam int SUS_MAX = SUSPEND_LATENCY_CYC + 2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_erase_run;
    status.busy [*8];
  endsequence
  sequence s_no_pause;
    !status.suspend_flag [*8];
  endsequence
  a_fill_all_ones: assert property (erase_all_value == 8'hFF)
    else $error("erase fill value is not all ones");
  a_fill_needs_latch: assert property (erase_all_fill |-> $past(status.write_latch_flag))
    else $error("erase started without write latch");
  a_fill_unprotected: assert property (erase_all_fill |->
    (protect.protect_level == 6'h00) && !protect.protect_complement)
    else $error("erase started while protected");
  a_erase_holds_busy: assert property (erase_all_fill |-> ##[0:2] s_erase_run)
    else $error("busy not held during erase");
  a_erase_no_pause: assert property (erase_all_fill |=> s_no_pause)
    else $error("whole erase was paused");
  a_refuse_no_fill: assert property (cmd_refused |-> !erase_all_fill)
    else $error("refused command still started erase");
  a_suspend_needs_busy: assert property ($rose(status.suspend_flag) |-> $past(status.busy))
    else $error("suspend accepted while idle");
  a_suspend_drops_busy: assert property ($rose(status.suspend_flag) |->
    ##[0:SUS_MAX] !status.busy)
    else $error("busy not cleared within suspend latency");
  a_resume_raises_busy: assert property ($fell(status.suspend_flag) |-> ##[1:52] status.busy)
    else $error("busy not raised after resume");
  a_pd_no_erase: assert property (status.powered_down |-> !erase_all_fill)
    else $error("erase started in power down");
  a_id_in_frame: assert property ($rose(sdo_oe) |-> !sel_n)
    else $error("id driven outside a frame");
endmodule // sfpc_props
bind sfpc_top sfpc_props #(.SUSPEND_LATENCY_CYC(SUSPEND_LATENCY_CYC)) u_props (
  .clk(clk), .rst(rst), .sel_n(sel_n), .protect(protect), .status(status),
  .erase_all_fill(erase_all_fill), .erase_all_value(erase_all_value),
  .cmd_refused(cmd_refused), .sdo_oe(sdo_oe));
`default_nettype wire

// ---- dv/sfpc_host.sv ----
/*
  Host serial controller model: select, a 48 ns serial clock and data.
  Assumes the bench calls xfer from one process only.
*/
`timescale 1ns/10ps
`default_nettype none
module sfpc_host (
  input wire logic clk,
  input wire logic sdo,
  output logic sel_n,
  output logic sck,
  output logic sdi
);
  // ****************************************
  // Frame task
  // ****************************************
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // The clock stands low between frames; data shows the inverse of its last value
  // so a device that samples outside a frame cannot see a stable opcode bit.
  task automatic xfer(input logic [7:0] op, input int nbits, input int nrd,
                      output logic [15:0] rd);
    logic [31:0] sh;
    int i;
    sh = {op, 24'h000000};
    rd = '0;
    @(negedge clk);
    sel_n = 1'b0;
    for (i = 0; i < nbits + nrd; i++) begin
      if (i < 32) begin
        sdi = sh[31 - i];
      end else begin
        sdi = ~sdi;
      end
      repeat (6) @(negedge clk);
      if (i >= nbits) begin
        rd = {rd[14:0], sdo};
      end
      sck = 1'b1;
      repeat (6) @(negedge clk);
      sck = 1'b0;
    end
    repeat (6) @(negedge clk);
    sel_n = 1'b1;
    sdi = ~sdi;
    repeat (12) @(negedge clk);
  endtask
endmodule // sfpc_host
`default_nettype wire

// ---- dv/sfpc_top_tb.sv ----
/*
  Self-checking bench for sfpc_top driven through the host model.
  Assumes shortened timing parameters; every input changes on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module sfpc_top_tb;
  import sfpc_pkg::*;
  // ****************************************
  // Harness
  // ****************************************
  localparam logic [7:0] DEV_ID = 8'hC3;  // Arbitrary neutral value.
  logic clk, rst, sel_n, sck, sdi, we_set, start, done, sdo, sdo_oe, fill, pause, refused, strobe;
  sfpc_protect_s protect;
  sfpc_kind_e kind, skind;
  sfpc_status_s status;
  logic [7:0] fill_val, acc_op;
  logic [15:0] d;
  int num_errors, total_checks, n_ref, n_fill, n_str, cyc, r0, k, i;
  logic [7:0] bad [2][7] = '{'{8'h01, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h44},
                             '{8'h01, 8'h02, 8'h32, 8'h42, 8'h01, 8'h02, 8'h32}};
  sfpc_top #(.ERASE_ALL_CYC(400), .SUSPEND_LATENCY_CYC(20), .POWER_DOWN_ENTRY_CYC(20),
    .WAKE_CYC(20), .WAKE_WITH_ID_TIME_CYC(30), .DEVICE_ID(DEV_ID)) i_dut (
    .clk(clk), .rst(rst), .sel_n(sel_n), .sck(sck), .sdi(sdi), .protect(protect),
    .write_enable_set(we_set), .other_busy_start(start), .other_kind(kind),
    .other_done(done), .sdo(sdo), .sdo_oe(sdo_oe), .status(status),
    .erase_all_fill(fill), .erase_all_value(fill_val), .op_pause(pause),
    .suspended_kind(skind), .cmd_refused(refused), .accepted_opcode(acc_op),
    .accepted_strobe(strobe));
  sfpc_host i_host (.clk(clk), .sdo(sdo), .sel_n(sel_n), .sck(sck), .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (refused === 1'b1) n_ref++;
    if (fill === 1'b1) n_fill++;
    if (strobe === 1'b1) n_str++;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] op, input int nbits);
    i_host.xfer(op, nbits, 0, d);
  endtask
  task automatic pulse(input int which);
    @(negedge clk);
    if (which == 0) we_set = 1'b1; else if (which == 1) start = 1'b1; else done = 1'b1;
    @(negedge clk);
    {we_set, start, done} = 3'b000;
  endtask
  task automatic wait_st(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (status[b] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(status[b], v);
  endtask
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {rst, we_set, start, done} = 4'b1000;
    protect = '0;
    kind = SFPC_OP_ERASE;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(status, 4'h0);
    r0 = n_ref;
    send(8'hC7, 8);
    check(n_ref - r0, 1);
    for (k = 0; k < 2; k++) begin
      pulse(0);
      protect = (k == 0) ? 9'h008 : 9'h001;
      r0 = n_ref;
      send(8'h60, 8);
      check(n_ref - r0, 1);
    end
    protect = '0;
    r0 = n_fill;
    send(8'hC7, 9);
    send(8'hC7, 7);
    check(n_fill - r0, 0);
    for (k = 0; k < 2; k++) begin
      pulse(0);
      r0 = n_fill;
      send(k == 0 ? 8'hC7 : 8'h60, 8);
      check(n_fill - r0, 1);
      check(fill_val, 8'hFF);
      check(status.busy, 1);
      send(8'h75, 8);
      check(status.suspend_flag, 0);
      r0 = n_str;
      send(8'hAB, 8);
      check({status.busy, status.powered_down}, 2'b10);
      check(n_str - r0, 0);
      wait_st(3, 1'b0, 600);
      check(status.write_latch_flag, 0);
    end
    send(8'h75, 8);
    check(status.suspend_flag, 0);
    for (k = 0; k < 2; k++) begin
      kind = k == 0 ? SFPC_OP_ERASE : SFPC_OP_PROGRAM;
      pulse(1);
      wait_st(3, 1'b1, 10);
      send(8'h75, 8);
      check(status.suspend_flag, 1);
      wait_st(3, 1'b0, 25);
      check({pause, skind}, {1'b1, kind});
      send(8'h75, 8);
      check(status.suspend_flag, 1);
      for (i = 0; i < 7; i++) begin
        r0 = n_ref;
        send(bad[k][i], 8);
        check(n_ref - r0, 1);
      end
      if (k == 0) begin
        send(8'h7A, 8);
        check(status.suspend_flag, 0);
        check(pause, 0);
        wait_st(3, 1'b1, 52);
        repeat (25) @(negedge clk);
        pulse(2);
        wait_st(3, 1'b0, 10);
      end else begin
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check(status.suspend_flag, 0);
        send(8'h7A, 8);
        repeat (60) @(negedge clk);
        check(status.busy, 0);
      end
    end
    r0 = n_str;
    send(8'hAB, 8);
    check(n_str - r0, 1);
    send(8'hB9, 7);
    repeat (30) @(negedge clk);
    check(status.powered_down, 0);
    send(8'hB9, 8);
    wait_st(0, 1'b1, 40);
    send(8'h05, 8);
    send(8'h75, 8);
    check(acc_op, 8'hB9);
    send(8'hAB, 8);
    wait_st(0, 1'b0, 40);
    send(8'hB9, 8);
    wait_st(0, 1'b1, 40);
    i_host.xfer(8'hAB, 32, 16, d);
    check(d, {DEV_ID, DEV_ID});
    repeat (40) @(negedge clk);
    check(status.powered_down, 0);
    close_out();
  end
endmodule // sfpc_top_tb
`default_nettype wire
